// [rtl/audio_port_pkg.sv]
// Constants for the mono codec serial audio port: register offsets,
// reset values, field positions and encodings.
// Assumes it is compiled before any module that refers to it.
package audio_port_pkg;

  // ==========================================================
  // Register offsets and reset values
  localparam logic [6:0] FMT_ADDR = 7'h04;
  localparam logic [6:0] CMP_ADDR = 7'h05;
  localparam logic [6:0] CLK_ADDR = 7'h06;
  localparam logic [6:0] TSL_ADDR = 7'h3b;
  localparam logic [6:0] PIN_ADDR = 7'h3c;
  localparam logic [8:0] FMT_RST = 9'h050;
  localparam logic [8:0] CMP_RST = 9'h000;
  localparam logic [8:0] CLK_RST = 9'h140;
  localparam logic [8:0] TSL_RST = 9'h000;
  localparam logic [8:0] PIN_RST = 9'h000;

  // ==========================================================
  // Field positions
  localparam int BCLK_POL_BIT = 8;
  localparam int FS_POL_BIT = 7;
  localparam int WORD_LEN_LSB = 5;
  localparam int FORMAT_LSB = 3;
  localparam int DPHS_BIT = 2;
  localparam int APHS_BIT = 1;
  localparam int BYTE_WIDTH_BIT = 5;
  localparam int DCM_LSB = 3;
  localparam int ACM_LSB = 1;
  localparam int MDIV_LSB = 5;
  localparam int BDIV_LSB = 2;
  localparam int CLKOE_BIT = 0;
  localparam int TSEN_BIT = 8;
  localparam int TRI_BIT = 7;
  localparam int MSW_BIT = 5;
  localparam int PE_BIT = 4;
  localparam int PS_BIT = 3;
  localparam int VARIANT_B_BIT = 1;
  localparam int TS9_BIT = 0;

  // ==========================================================
  // Encodings and counts
  localparam logic [1:0] FMT_RJ = 2'h0;
  localparam logic [1:0] FMT_LJ = 2'h1;
  localparam logic [1:0] FMT_I2S = 2'h2;
  localparam logic [1:0] FMT_PCM = 2'h3;
  localparam logic [1:0] CM_MU = 2'h2;
  localparam logic [1:0] CM_A = 2'h3;
  localparam logic [10:0] WL_BYTE = 11'h008;
  localparam int HALF_W = 9;

endpackage : audio_port_pkg

// [rtl/audio_serial_port.sv]
// Serial audio port of a mono voice codec: master/slave clocking,
// framing formats, capture pin control and G.711 companding.
// Assumes pins are synchronous to mclk and registers written on the
// simple register port below.
`timescale 1ns/1ps
`default_nettype none

// Function
// - clock output enable makes port clock master
// - sample rate comes from master clock divider
// - audio only in left slot normally
// - capture pin defaults pulled low, mask configurable
// - format from format field, slot enable, variant
// - all words move most significant bit first
// - right-justified: LSB ends at frame sync fall
// - left-justified: MSB at first edge, high phase
// - I2S: low phase, MSB at second edge
// - PCM A: low phase, MSB at second edge
// - phase bits move data to right phase, or one word later in PCM modes
// - time slot field sets start, zero immediate
// - release edge bit picks falling or rising release in time slot mode
// - separate compand modes for playback and capture
// - linear samples map to sign/exponent/mantissa bytes
// - mu-law inverts all bits, A-law even bits
// - compand byte width forces 8-bit words
module audio_serial_port (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Register port
  input wire logic reg_wr,
  input wire logic [6:0] reg_addr,
  input wire logic [8:0] reg_wdata,
  output logic [8:0] reg_rdata,
  // Clock pins
  input wire logic bclk_in,
  output logic bclk_out,
  output logic bclk_oe_n,
  input wire logic fs_in,
  output logic fs_out,
  output logic fs_oe_n,
  // Data pins
  input wire logic playback_serial_in,
  output logic capture_serial_out,
  output logic capture_oe_n,
  output logic capture_pull_up,
  output logic capture_pull_down,
  // Converter side
  input wire logic [31:0] capture_word,
  output logic capture_take,
  output logic [31:0] playback_word,
  output logic playback_valid,
  output logic sample_tick
);

  // ==========================================================
  // Registers
  logic [8:0] fmt_q, cmp_q, clk_q, tsl_q, pin_q;
  logic [8:0] rd_mux;

  assign rd_mux = (reg_addr == audio_port_pkg::FMT_ADDR) ? fmt_q :
                  (reg_addr == audio_port_pkg::CMP_ADDR) ? cmp_q :
                  (reg_addr == audio_port_pkg::CLK_ADDR) ? clk_q :
                  (reg_addr == audio_port_pkg::TSL_ADDR) ? tsl_q :
                  (reg_addr == audio_port_pkg::PIN_ADDR) ? pin_q : 9'h000;

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      fmt_q <= audio_port_pkg::FMT_RST;
      cmp_q <= audio_port_pkg::CMP_RST;
      clk_q <= audio_port_pkg::CLK_RST;
      tsl_q <= audio_port_pkg::TSL_RST;
      pin_q <= audio_port_pkg::PIN_RST;
      reg_rdata <= 9'h000;
    end
    else
    begin
      if (reg_wr && reg_addr == audio_port_pkg::FMT_ADDR) fmt_q <= reg_wdata;
      if (reg_wr && reg_addr == audio_port_pkg::CMP_ADDR) cmp_q <= reg_wdata;
      if (reg_wr && reg_addr == audio_port_pkg::CLK_ADDR) clk_q <= reg_wdata;
      if (reg_wr && reg_addr == audio_port_pkg::TSL_ADDR) tsl_q <= reg_wdata;
      if (reg_wr && reg_addr == audio_port_pkg::PIN_ADDR) pin_q <= reg_wdata;
      reg_rdata <= rd_mux;
    end
  end

  // ==========================================================
  // Field decode
  logic bit_clock_polarity, frame_sync_polarity, dac_phs, adc_phs, compand_byte_width, clkoe;
  logic ts_en, tri_neg, mask_sw, pull_en, pull_up, pcm_variant_b_select;
  logic [1:0] word_length_select, audio_format_select, dac_cm, adc_cm;
  logic [2:0] mdiv, bdiv;
  logic [9:0] timeslot_start;

  assign bit_clock_polarity = fmt_q[audio_port_pkg::BCLK_POL_BIT];
  assign frame_sync_polarity = fmt_q[audio_port_pkg::FS_POL_BIT];
  assign word_length_select = fmt_q[audio_port_pkg::WORD_LEN_LSB +: 2];
  assign audio_format_select = fmt_q[audio_port_pkg::FORMAT_LSB +: 2];
  assign dac_phs = fmt_q[audio_port_pkg::DPHS_BIT];
  assign adc_phs = fmt_q[audio_port_pkg::APHS_BIT];
  assign compand_byte_width = cmp_q[audio_port_pkg::BYTE_WIDTH_BIT];
  assign dac_cm = cmp_q[audio_port_pkg::DCM_LSB +: 2];
  assign adc_cm = cmp_q[audio_port_pkg::ACM_LSB +: 2];
  assign mdiv = clk_q[audio_port_pkg::MDIV_LSB +: 3];
  assign bdiv = clk_q[audio_port_pkg::BDIV_LSB +: 3];
  assign clkoe = clk_q[audio_port_pkg::CLKOE_BIT];
  assign ts_en = pin_q[audio_port_pkg::TSEN_BIT];
  assign tri_neg = pin_q[audio_port_pkg::TRI_BIT];
  assign mask_sw = pin_q[audio_port_pkg::MSW_BIT];
  assign pull_en = pin_q[audio_port_pkg::PE_BIT];
  assign pull_up = pin_q[audio_port_pkg::PS_BIT];
  assign pcm_variant_b_select = pin_q[audio_port_pkg::VARIANT_B_BIT];
  assign timeslot_start = {pin_q[audio_port_pkg::TS9_BIT], tsl_q};

  // ==========================================================
  // Internal clock: half-ticks of the internal master clock, 512 per frame
  logic [2:0] dv_q;
  logic [audio_port_pkg::HALF_W-1:0] h_q;
  logic tick;

  assign tick = (dv_q == mdiv);

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      dv_q <= 3'h0;
      h_q <= '0;
      sample_tick <= 1'b0;
      bclk_out <= 1'b0;
      fs_out <= 1'b0;
      bclk_oe_n <= 1'b1;
      fs_oe_n <= 1'b1;
    end
    else
    begin
      dv_q <= tick ? 3'h0 : 3'(dv_q + 3'h1);
      h_q <= h_q + {8'h00, tick};
      sample_tick <= tick && (&h_q);
      bclk_out <= h_q[bdiv];
      fs_out <= ~h_q[audio_port_pkg::HALF_W-1] ^ frame_sync_polarity;
      bclk_oe_n <= ~clkoe;
      fs_oe_n <= ~clkoe;
    end
  end

  // ==========================================================
  // Edge detection and frame tracking
  logic b_eff, b_eff_q, fs_eff, phase_q, rise_ev, fall_ev, new_ph;
  logic [10:0] cnt_q, half_len_q, idx_now;

  assign b_eff = (clkoe ? bclk_out : bclk_in) ^ bit_clock_polarity;
  assign fs_eff = (clkoe ? fs_out : fs_in) ^ frame_sync_polarity;
  assign rise_ev = b_eff && !b_eff_q;
  assign fall_ev = !b_eff && b_eff_q;
  assign new_ph = (fs_eff != phase_q);
  assign idx_now = new_ph ? 11'h000 : cnt_q;

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      b_eff_q <= 1'b0;
      phase_q <= 1'b0;
      cnt_q <= 11'h000;
      half_len_q <= 11'h000;
    end
    else
    begin
      b_eff_q <= b_eff;
      if (rise_ev)
      begin
        phase_q <= fs_eff;
        cnt_q <= idx_now + 11'h001;
        if (new_ph) half_len_q <= cnt_q;
      end
    end
  end

  // ==========================================================
  // Format, word length and slot placement
  logic is_pcm, ts, pcm_b, act, same_ph;
  logic [10:0] wl11, base;

  assign is_pcm = (audio_format_select == audio_port_pkg::FMT_PCM);
  assign ts = is_pcm && ts_en;
  assign pcm_b = (audio_format_select == audio_port_pkg::FMT_RJ) && pcm_variant_b_select;
  assign act = !pcm_b && (audio_format_select == audio_port_pkg::FMT_RJ ||
                          audio_format_select == audio_port_pkg::FMT_LJ);
  assign same_ph = is_pcm || pcm_b;
  assign wl11 = compand_byte_width ? audio_port_pkg::WL_BYTE :
                (word_length_select == 2'h0) ? 11'd16 : (word_length_select == 2'h1) ? 11'd20 :
                (word_length_select == 2'h2) ? 11'd24 : 11'd32;
  assign base = ts ? {1'b0, timeslot_start} :
                pcm_b ? 11'h000 :
                (audio_format_select == audio_port_pkg::FMT_LJ) ? 11'h000 :
                (audio_format_select == audio_port_pkg::FMT_RJ) ?
                  ((half_len_q > wl11) ? half_len_q - wl11 : 11'h000) :
                11'h001;

  // Returns hit flag and bit position from the MSB for one direction.
  // All format state arrives as arguments, so a continuous assignment that calls it follows every change.
  function automatic logic [11:0] word_pos(input logic ph, input logic [10:0] idx, input logic right,
                                           input logic [10:0] b0, input logic [10:0] wl, input logic a,
                                           input logic sp);
    logic [10:0] st;
    logic want;
    begin
      st = (right && sp) ? 11'(b0 + wl) : b0;
      want = (right && !sp) ? ~a : a;
      word_pos = {(ph == want) && (idx >= st) && (idx < 11'(st + wl)), 11'(idx - st)};
    end
  endfunction : word_pos

  // ==========================================================
  // G.711 compander
  function automatic logic [7:0] mu_enc(input logic [12:0] x);
    logic [12:0] mag;
    logic [13:0] b;
    logic [13:0] sh;
    logic [2:0] e;
    begin
      mag = x[12] ? 13'(~x + 13'h1) : x;
      b = {1'b0, mag} + 14'h21;
      if (b > 14'h1fff) b = 14'h1fff;
      e = 3'h0;
      for (int i = 1; i < 8; i++) if (b[i + 5]) e = 3'(i);
      sh = b >> ({1'b0, e} + 4'h1);
      mu_enc = ~{x[12], e, sh[3:0]};
    end
  endfunction : mu_enc

  function automatic logic [7:0] a_enc(input logic [11:0] x);
    logic [11:0] mag;
    logic [11:0] sh;
    logic [2:0] e;
    begin
      mag = x[11] ? 12'(~x + 12'h1) : x;
      if (mag > 12'h7ff) mag = 12'h7ff;
      e = 3'h0;
      for (int i = 1; i < 8; i++) if (mag[i + 3]) e = 3'(i);
      sh = (e == 3'h0) ? mag : mag >> (e - 3'h1);
      a_enc = {~x[11], e, sh[3:0]} ^ 8'h55;
    end
  endfunction : a_enc

  function automatic logic [12:0] mu_dec(input logic [7:0] c);
    logic [7:0] v;
    logic [13:0] t;
    begin
      v = ~c;
      t = (14'({1'b1, v[3:0], 1'b1}) << v[6:4]) - 14'h21;
      mu_dec = v[7] ? 13'(~t[12:0] + 13'h1) : t[12:0];
    end
  endfunction : mu_dec

  function automatic logic [11:0] a_dec(input logic [7:0] c);
    logic [7:0] v;
    logic [11:0] t;
    begin
      v = c ^ 8'h55;
      t = (v[6:4] == 3'h0) ? {8'h00, v[3:0]} : 12'({1'b1, v[3:0]}) << (v[6:4] - 3'h1);
      a_dec = v[7] ? t : 12'(~t + 12'h1);
    end
  endfunction : a_dec

  logic [31:0] cap_src, play_src, rx_q;

  assign cap_src = (adc_cm == audio_port_pkg::CM_MU) ? {mu_enc(capture_word[31:19]), 24'h000000} :
                   (adc_cm == audio_port_pkg::CM_A) ? {a_enc(capture_word[31:20]), 24'h000000} :
                   capture_word;
  assign play_src = (dac_cm == audio_port_pkg::CM_MU) ? {mu_dec(rx_q[31:24]), 19'h00000} :
                    (dac_cm == audio_port_pkg::CM_A) ? {a_dec(rx_q[31:24]), 20'h00000} :
                    rx_q;

  // ==========================================================
  // Capture transmitter: changes on falling edges, MSB first
  logic [11:0] tx;
  logic tx_hit, tx_drv_q, tx_hold_q, tx_bit_q;
  logic [10:0] tx_pos;
  logic [31:0] tx_word_q;

  assign tx = word_pos(fs_eff, idx_now, adc_phs, base, wl11, act, same_ph);
  assign tx_hit = tx[11];
  assign tx_pos = tx[10:0];

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      tx_drv_q <= 1'b0;
      tx_hold_q <= 1'b0;
      tx_bit_q <= 1'b0;
      tx_word_q <= 32'h00000000;
      capture_take <= 1'b0;
    end
    else
    begin
      capture_take <= fall_ev && tx_hit && tx_pos == 11'h000;
      if (fall_ev)
      begin
        if (tx_hit)
        begin
          tx_drv_q <= 1'b1;
          tx_hold_q <= 1'b0;
          tx_bit_q <= (tx_pos == 11'h000) ? cap_src[31] : tx_word_q[~tx_pos[4:0]];
          if (tx_pos == 11'h000) tx_word_q <= cap_src;
        end
        else if (tx_drv_q && ts && !tri_neg)
          tx_hold_q <= 1'b1;
        else
          tx_drv_q <= 1'b0;
      end
      else if (rise_ev && tx_hold_q)
      begin
        tx_drv_q <= 1'b0;
        tx_hold_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Capture pin: mask forces a state, otherwise data, or an idle pull-down while pull enable is clear
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      capture_serial_out <= 1'b0;
      capture_oe_n <= 1'b1;
      capture_pull_up <= 1'b0;
      capture_pull_down <= 1'b1;
    end
    else
    begin
      capture_serial_out <= mask_sw ? pull_up : tx_bit_q;
      capture_oe_n <= mask_sw ? pull_en : !tx_drv_q;
      capture_pull_up <= mask_sw && pull_en && pull_up;
      capture_pull_down <= mask_sw ? (pull_en && !pull_up) : (!tx_drv_q && !pull_en);
    end
  end

  // ==========================================================
  // Playback receiver: samples on rising edges
  logic [11:0] rx;
  logic rx_done_q;

  assign rx = word_pos(fs_eff, idx_now, dac_phs, base, wl11, act, same_ph);

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      rx_q <= 32'h00000000;
      rx_done_q <= 1'b0;
      playback_word <= 32'h00000000;
      playback_valid <= 1'b0;
    end
    else
    begin
      rx_done_q <= rise_ev && rx[11] && rx[10:0] == wl11 - 11'h001;
      if (rise_ev && rx[11])
      begin
        if (rx[10:0] == 11'h000) rx_q <= {playback_serial_in, 31'h00000000};
        else rx_q[~rx[4:0]] <= playback_serial_in;
      end
      playback_valid <= rx_done_q;
      if (rx_done_q) playback_word <= play_src;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  sequence s_mask_drive;
    mask_sw && !pull_en ##1 mask_sw && !pull_en;
  endsequence

  chk_master_pins_on: assert property (clkoe |=> !bclk_oe_n && !fs_oe_n)
    else $error("clock pins not driven in master mode");
  chk_rate_tick_wrap: assert property (tick && (&h_q) |=> sample_tick ##1 !sample_tick)
    else $error("sample tick not tied to internal clock wrap");
  chk_left_slot_only: assert property (fall_ev && tx_hit && !adc_phs |-> fs_eff == act)
    else $error("capture data outside left slot");
  chk_mask_drive_level: assert property (s_mask_drive |-> !capture_oe_n && capture_serial_out == $past(pull_up))
    else $error("mask drive state wrong");
  chk_idle_pull_low: assert property (!mask_sw && !pull_en && !tx_drv_q |=> capture_pull_down)
    else $error("idle capture pin not pulled low");
  chk_word_done_valid: assert property (rx_done_q |=> playback_valid && playback_word == $past(play_src))
    else $error("playback word not delivered");
  chk_slot_start_base: assert property (ts |-> base == {1'b0, timeslot_start})
    else $error("time slot start mismatch");
  chk_release_neg_edge: assert property (fall_ev && ts && tri_neg && tx_drv_q && !tx_hit |=> !tx_drv_q)
    else $error("capture line not released on falling edge");
  chk_byte_word_len: assert property (compand_byte_width |-> wl11 == audio_port_pkg::WL_BYTE)
    else $error("byte width not forcing 8-bit words");

endmodule : audio_serial_port

`default_nettype wire

// [sim/host_link_model.sv]
// Host controller model for the audio port in slave mode: bit clock, frame sync and playback data.
// Assumes the block samples on rising bit clock edges and shifts capture data out on falling ones.
`timescale 1ns/1ps
`default_nettype none

module host_link_model (
  // Clock and control
  input wire logic mclk,
  input wire logic en,
  input wire logic [5:0] wl,
  input wire logic [5:0] start,
  input wire logic word_hi,
  input wire logic [31:0] tx_word,
  // Link pins
  input wire logic sdata_in,
  output logic bclk,
  output logic fs,
  output logic sdata,
  // Results
  output logic [31:0] rx_bits,
  output int frames
);
  // ==========================================================
  // Frame generator
  // Each phase holds 32 bit clocks of 12 mclk; while disabled the clock holds its last level, low before the first frame and high after one.
  localparam int HALF = 6;
  int k;
  int ph;
  logic lvl;
  logic in_word;

  initial
  begin
    bclk = 1'b0;
    fs = 1'b0;
    sdata = 1'b0;
    rx_bits = '0;
    frames = 0;
    forever
    begin
      @(posedge mclk);
      #1;
      if (en)
      begin
        for (ph = 0; ph < 2; ph++)
        begin
          lvl = (ph == 0);
          for (k = 0; k < 32; k++)
          begin
            in_word = (lvl == word_hi) && (k >= int'(start)) && (k < int'(start) + int'(wl));
            bclk = 1'b0;
            if (k == 0)
            begin
              fs = lvl;
            end
            if (k == 0 && lvl == word_hi)
            begin
              rx_bits = '0;
            end
            // Outside its word the line toggles so that a stale value never looks valid.
            sdata = in_word ? tx_word[int'(wl) - 1 - (k - int'(start))] : ~sdata;
            repeat (HALF) @(posedge mclk);
            #1;
            if (in_word)
            begin
              rx_bits = {rx_bits[30:0], sdata_in};
            end
            bclk = 1'b1;
            repeat (HALF) @(posedge mclk);
            #1;
          end
        end
        frames++;
      end
    end
  end
endmodule : host_link_model

`default_nettype wire

// [sim/mono_codec_audio_serial_port_bench.sv]
// Self-checking bench for the serial audio port: registers, pin modes, master clocking and formats.
// Assumes the host model file is compiled before this one.
`timescale 1ns/1ps
`default_nettype none

module mono_codec_audio_serial_port_bench;
  logic mclk, rstn, reg_wr;
  logic [6:0] reg_addr;
  logic [8:0] reg_wdata, reg_rdata, rv;
  logic bclk_out, bclk_oe_n, fs_out, fs_oe_n, capture_serial_out, capture_oe_n, capture_pull_up, capture_pull_down;
  logic [31:0] capture_word, playback_word, tx_word, rx_bits, play_exp;
  logic capture_take, playback_valid, sample_tick, link_en, word_hi, bclk, fs, sdata, cap_pin;
  logic [5:0] wl, start;
  int frames, n_mismatch, n_compared, i, cnt;

  // Capture pin level seen by the host, including the weak pulls.
  assign cap_pin = capture_oe_n ? capture_pull_up : capture_serial_out;

  audio_serial_port audio_serial_port_i (.mclk(mclk), .rstn(rstn), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .bclk_in(bclk), .bclk_out(bclk_out), .bclk_oe_n(bclk_oe_n),
    .fs_in(fs), .fs_out(fs_out), .fs_oe_n(fs_oe_n), .playback_serial_in(sdata),
    .capture_serial_out(capture_serial_out), .capture_oe_n(capture_oe_n), .capture_pull_up(capture_pull_up),
    .capture_pull_down(capture_pull_down), .capture_word(capture_word), .capture_take(capture_take),
    .playback_word(playback_word), .playback_valid(playback_valid), .sample_tick(sample_tick));

  host_link_model host_link_model_i (.mclk(mclk), .en(link_en), .wl(wl), .start(start), .word_hi(word_hi),
    .tx_word(tx_word), .sdata_in(cap_pin), .bclk(bclk), .fs(fs), .sdata(sdata), .rx_bits(rx_bits),
    .frames(frames));

  // ==========================================================
  // Clock, reset and watchdog
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  initial
  begin
    repeat (60000) @(posedge mclk);
    n_mismatch++;
    test_done();
  end

  // ==========================================================
  // Shared tasks
  task automatic tick();
    @(posedge mclk);
    #1;
  endtask : tick

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [6:0] a, input logic [8:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    tick();
    reg_wr = 1'b0;
    tick();
  endtask : wr

  task automatic rd(input logic [6:0] a, output logic [8:0] d);
    reg_addr = a;
    tick();
    d = reg_rdata;
  endtask : rd

  task automatic pins(input logic [8:0] v, input logic [3:0] exp);
    wr(audio_port_pkg::PIN_ADDR, v);
    repeat (3) tick();
    check({28'h0, capture_oe_n, capture_oe_n ? 1'b0 : capture_serial_out, capture_pull_up, capture_pull_down},
          {28'h0, exp});
  endtask : pins

  task automatic run_fmt(input logic [8:0] r04, r05, r3b, r3c, input int w, s, input logic h,
                         input logic [31:0] cw, exp_cap);
    int n;
    wr(audio_port_pkg::FMT_ADDR, r04);
    wr(audio_port_pkg::CMP_ADDR, r05);
    wr(audio_port_pkg::TSL_ADDR, r3b);
    wr(audio_port_pkg::PIN_ADDR, r3c);
    wl = 6'(w);
    start = 6'(s);
    word_hi = h;
    capture_word = cw;
    n = frames;
    for (i = 0; i < 4000 && frames < n + 3; i++) tick();
    check(rx_bits, exp_cap);
    if (r05[4:3] != 2'h0)
      check(playback_word, play_exp);
    else
      check(playback_word >> (32 - w), tx_word & ((32'h1 << w) - 32'h1));
  endtask : run_fmt

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done

  // ==========================================================
  // Test sequence
  initial
  begin
    rstn = 1'b0;
    reg_wr = 1'b0;
    reg_addr = 7'h00;
    reg_wdata = 9'h000;
    capture_word = 32'h0;
    link_en = 1'b0;
    wl = 6'h10;
    start = 6'h00;
    word_hi = 1'b1;
    tx_word = 32'h5a3c_96e1;
    n_mismatch = 0;
    n_compared = 0;
    repeat (3) @(posedge mclk);
    #1;
    rstn = 1'b1;
    rd(audio_port_pkg::FMT_ADDR, rv); check(32'(rv), 32'h050);
    rd(audio_port_pkg::CMP_ADDR, rv); check(32'(rv), 32'h000);
    rd(audio_port_pkg::CLK_ADDR, rv); check(32'(rv), 32'h140);
    rd(audio_port_pkg::TSL_ADDR, rv); check(32'(rv), 32'h000);
    rd(audio_port_pkg::PIN_ADDR, rv); check(32'(rv), 32'h000);
    check({30'h0, bclk_oe_n, fs_oe_n}, 32'h3);
    check({28'h0, capture_oe_n, 1'b0, capture_pull_up, capture_pull_down}, 32'h9);
    wr(audio_port_pkg::TSL_ADDR, 9'h1a5);
    rd(audio_port_pkg::TSL_ADDR, rv); check(32'(rv), 32'h1a5);
    wr(7'h07, 9'h1ff);
    rd(7'h07, rv); check(32'(rv), 32'h000);
    // Master mode: divider 2 gives a half bit clock of 3 mclk and a frame of 1536 mclk.
    wr(audio_port_pkg::CLK_ADDR, 9'h141);
    repeat (2) tick();
    check({30'h0, bclk_oe_n, fs_oe_n}, 32'h0);
    cnt = 0;
    for (i = 0; i < 60; i++)
    begin
      rv[0] = bclk_out;
      tick();
      cnt += int'(bclk_out != rv[0]);
    end
    check(32'(cnt >= 19 && cnt <= 21), 32'h1);
    for (i = 0; i < 3000 && sample_tick !== 1'b1; i++) tick();
    tick();
    for (cnt = 1; cnt < 3000 && sample_tick !== 1'b1; cnt++) tick();
    check(32'(cnt), 32'd1536);
    wr(audio_port_pkg::CLK_ADDR, audio_port_pkg::CLK_RST);
    repeat (2) tick();
    check({30'h0, bclk_oe_n, fs_oe_n}, 32'h3);
    pins(9'h020, 4'b0000);
    pins(9'h028, 4'b0100);
    pins(9'h030, 4'b1001);
    pins(9'h038, 4'b1010);
    pins(9'h010, 4'b1000);
    // Slave formats with a host clock; word length 16 unless the byte width bit is set.
    link_en = 1'b1;
    run_fmt(9'h000, 9'h000, 9'h000, 9'h000, 16, 16, 1'b1, 32'ha5c3_9e17, 32'h0000_a5c3);
    run_fmt(9'h008, 9'h000, 9'h000, 9'h000, 16, 0, 1'b1, 32'ha5c3_9e17, 32'h0000_a5c3);
    run_fmt(9'h010, 9'h000, 9'h000, 9'h000, 16, 1, 1'b0, 32'h3c96_0000, 32'h0000_3c96);
    run_fmt(9'h018, 9'h000, 9'h000, 9'h000, 16, 1, 1'b0, 32'ha5c3_9e17, 32'h0000_a5c3);
    run_fmt(9'h000, 9'h000, 9'h000, 9'h002, 16, 0, 1'b0, 32'ha5c3_9e17, 32'h0000_a5c3);
    run_fmt(9'h018, 9'h000, 9'h003, 9'h100, 16, 3, 1'b0, 32'ha5c3_9e17, 32'h0000_a5c3);
    run_fmt(9'h018, 9'h000, 9'h000, 9'h180, 16, 0, 1'b0, 32'h6b2d_0000, 32'h0000_6b2d);
    run_fmt(9'h008, 9'h020, 9'h000, 9'h000, 8, 0, 1'b1, 32'ha5c3_9e17, 32'h0000_00a5);
    run_fmt(9'h008, 9'h024, 9'h000, 9'h000, 8, 0, 1'b1, 32'h0000_0000, 32'h0000_00ff);
    run_fmt(9'h008, 9'h026, 9'h000, 9'h000, 8, 0, 1'b1, 32'h0000_0000, 32'h0000_00d5);
    // Playback mu-law: byte e1 expands to linear 89 in the top 13 bits.
    play_exp = 32'h02c8_0000;
    run_fmt(9'h008, 9'h030, 9'h000, 9'h000, 8, 0, 1'b1, 32'ha5c3_9e17, 32'h0000_00a5);
    // Right phase: left-justified moves to the low phase, PCM B starts one word later.
    run_fmt(9'h00e, 9'h000, 9'h000, 9'h000, 16, 0, 1'b0, 32'ha5c3_9e17, 32'h0000_a5c3);
    run_fmt(9'h006, 9'h000, 9'h000, 9'h002, 16, 16, 1'b0, 32'ha5c3_9e17, 32'h0000_a5c3);
    test_done();
  end
endmodule : mono_codec_audio_serial_port_bench

`default_nettype wire
